// ---- hdl/fss_pkg.sv ----
// constants and types for the flash status and timing setup block
package fss_pkg;

  // ------------------------------------------------------------
  // clock and power timing
  // ------------------------------------------------------------
  localparam int CORE_MHZ = 125;
  localparam int STANDBY_US = 100;
  localparam int SLEEP_US = 1000;
  localparam int WAKE_NS = 2000;
  localparam int STANDBY_CYC = STANDBY_US * CORE_MHZ;
  localparam int SLEEP_CYC = SLEEP_US * CORE_MHZ;
  localparam int WAKE_CYC = (WAKE_NS * CORE_MHZ) / 1000;
  localparam int IDLE_W = 24;

  // ------------------------------------------------------------
  // command bytes and frame lengths
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_RD = 8'h15;
  localparam logic [7:0] CMD_RD_AUTO = 8'h16;
  localparam logic [7:0] CMD_WR = 8'h17;
  localparam logic [7:0] CMD_WR_AUTO = 8'h18;
  localparam logic [7:0] CMD_ERASE = 8'h19;
  localparam logic [7:0] CMD_VALID = 8'h1a;
  localparam logic [7:0] CMD_REG_WR = 8'h1d;
  localparam logic [7:0] CMD_REG_RD = 8'h1e;
  localparam logic [7:0] CMD_CTRL = 8'h1f;
  localparam logic [7:0] CMD_STATUS = 8'h22;
  localparam logic [2:0] LEN_LONG = 3'h7;
  localparam logic [2:0] LEN_ADDR = 3'h5;
  localparam logic [2:0] LEN_AUTO = 3'h4;
  localparam logic [2:0] LEN_STATUS = 3'h3;
  localparam logic [5:0] RD_AT_LONG = 6'h20;
  localparam logic [5:0] RD_AT_SHORT = 6'h08;
  localparam logic [15:0] CTRL_CLEAR = 16'h0040;

  // ------------------------------------------------------------
  // quick status bit positions
  // ------------------------------------------------------------
  localparam int QS_FAIL = 0;
  localparam int QS_RD_ERR = 1;
  localparam int QS_INVALID = 2;
  localparam int QS_DEV_BUSY = 3;
  localparam int QS_ER_BUSY = 4;
  localparam int QS_WR_BUSY = 5;
  localparam int QS_FRAME = 6;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  localparam int NREG = 11;
  localparam logic [15:0] LOCK_ADDR = 16'hf004;
  localparam logic [15:0] UNLOCK_KEY = 16'h2bc0;
  localparam logic [15:0] LOCK_KEY = 16'h03c0;
  localparam logic [15:0] LOCK_RST = LOCK_KEY;
  localparam logic [15:0] TMG_OFS [NREG] = '{16'h8006, 16'h8008, 16'h8009, 16'h800d,
    16'h800e, 16'h8010, 16'h8014, 16'h8015, 16'h8016, 16'h8017, 16'h8018};
  localparam logic [15:0] TMG_RST [NREG] = '{16'h0764, 16'h307d, 16'h0d0d, 16'h0d0d,
    16'h01f4, 16'h0d0d, 16'h0032, 16'h83d6, 16'h186a, 16'h0d0d, 16'h0064};

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_SLEEP = 2'b11,
    PWR_WAKE = 2'b10
  } fss_pwr_e;

  typedef enum logic [1:0] {
    OP_PROG = 2'b00,
    OP_ERASE = 2'b01,
    OP_VALID = 2'b10
  } fss_kind_e;

  typedef struct packed {
    fss_kind_e kind;
    logic [20:0] addr;
    logic [15:0] data;
  } fss_op_s;

endpackage : fss_pkg

// ---- hdl/fss_flash_status.sv ----
// serial flash quick status, error flags, timing registers and power states
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module fss_flash_status #(
  parameter int STANDBY_CYC = fss_pkg::STANDBY_CYC,
  parameter int SLEEP_CYC = fss_pkg::SLEEP_CYC,
  parameter logic [3:0] REV_ID = 4'h5 // arbitrary value
) (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // serial pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // flash array side
  output logic o_rd_req,
  output logic o_op_req,
  output fss_pkg::fss_op_s o_op,
  input wire logic [15:0] i_rd_data,
  input wire logic i_op_done,
  input wire logic i_op_fail,
  // algorithm timing and power
  output logic [fss_pkg::NREG-1:0][15:0] o_timing,
  output fss_pkg::fss_pwr_e o_pwr_state,
  output logic o_unlocked
);

  // ------------------------------------------------------------
  // pin synchronisers and edges
  // ------------------------------------------------------------
  logic [1:0] cs_s_q, sck_s_q, si_s_q;
  logic cs_d_q, sck_d_q;
  logic cs_fall, cs_rise, sck_rise, sck_fall;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_s_q <= 2'b11;
      sck_s_q <= 2'b00;
      si_s_q <= 2'b00;
      cs_d_q <= 1'b1;
      sck_d_q <= 1'b0;
    end else if (i_ce) begin
      cs_s_q <= {cs_s_q[0], i_cs_n};
      sck_s_q <= {sck_s_q[0], i_sck};
      si_s_q <= {si_s_q[0], i_si};
      cs_d_q <= cs_s_q[1];
      sck_d_q <= sck_s_q[1];
    end
  end

  assign cs_fall = cs_d_q & ~cs_s_q[1];
  assign cs_rise = ~cs_d_q & cs_s_q[1];
  assign sck_rise = ~sck_d_q & sck_s_q[1] & ~cs_s_q[1];
  assign sck_fall = sck_d_q & ~sck_s_q[1] & ~cs_s_q[1];

  // ------------------------------------------------------------
  // frame decode helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] cmd_len(input logic [7:0] c);
    case (c)
      fss_pkg::CMD_RD, fss_pkg::CMD_WR, fss_pkg::CMD_REG_WR,
      fss_pkg::CMD_REG_RD: cmd_len = fss_pkg::LEN_LONG;
      fss_pkg::CMD_RD_AUTO, fss_pkg::CMD_WR_AUTO,
      fss_pkg::CMD_CTRL: cmd_len = fss_pkg::LEN_AUTO;
      fss_pkg::CMD_ERASE, fss_pkg::CMD_VALID: cmd_len = fss_pkg::LEN_ADDR;
      fss_pkg::CMD_STATUS: cmd_len = fss_pkg::LEN_STATUS;
      default: cmd_len = 3'h0;
    endcase
  endfunction : cmd_len

  function automatic logic [5:0] rd_at(input logic [7:0] c);
    case (c)
      fss_pkg::CMD_RD, fss_pkg::CMD_REG_RD: rd_at = fss_pkg::RD_AT_LONG;
      fss_pkg::CMD_RD_AUTO, fss_pkg::CMD_STATUS: rd_at = fss_pkg::RD_AT_SHORT;
      default: rd_at = 6'h00;
    endcase
  endfunction : rd_at

  // ------------------------------------------------------------
  // receive shifter
  // ------------------------------------------------------------
  logic [5:0] bit_cnt_q;
  logic [6:0] rx_sh_q;
  logic [7:0] rx_q [7];
  logic rose_q;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_q <= 6'h00;
      rx_sh_q <= 7'h00;
      rose_q <= 1'b0;
      for (int i = 0; i < 7; i++) begin
        rx_q[i] <= 8'h00;
      end
    end else if (i_ce) begin
      rose_q <= sck_rise;
      if (cs_fall) begin
        bit_cnt_q <= 6'h00;
        rx_q[0] <= 8'h00;
      end else if (sck_rise) begin
        rx_sh_q <= {rx_sh_q[5:0], si_s_q[1]};
        if (bit_cnt_q != 6'h3f) begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
        end
        if (bit_cnt_q[2:0] == 3'h7 && bit_cnt_q[5:3] != 3'h7) begin
          rx_q[bit_cnt_q[5:3]] <= {rx_sh_q, si_s_q[1]};
        end
      end
    end
  end

  logic [7:0] cmd;
  logic [2:0] len;
  logic complete, exec, rd_go;
  logic [20:0] word_addr;
  logic [15:0] reg_addr, data_full, data_auto;

  assign cmd = rx_q[0];
  assign len = cmd_len(cmd);
  assign complete = (len != 3'h0) && (bit_cnt_q[5:3] >= len);
  assign exec = cs_rise & complete;
  assign rd_go = rose_q && (rd_at(cmd) != 6'h00) && (bit_cnt_q == rd_at(cmd));
  assign word_addr = {rx_q[1][4:0], rx_q[2], rx_q[3]};
  assign reg_addr = {rx_q[2], rx_q[3]};
  assign data_full = {rx_q[4], rx_q[5]};
  assign data_auto = {rx_q[1], rx_q[2]};

  // ------------------------------------------------------------
  // timing registers and lock
  // ------------------------------------------------------------
  logic [15:0] lock_q;
  logic reg_wr;
  logic [15:0] reg_rd_val;

  assign reg_wr = exec && cmd == fss_pkg::CMD_REG_WR;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_q <= fss_pkg::LOCK_RST;
      o_unlocked <= 1'b0;
    end else if (i_ce) begin
      if (reg_wr && reg_addr == fss_pkg::LOCK_ADDR) begin
        lock_q <= data_full;
        o_unlocked <= (data_full == fss_pkg::UNLOCK_KEY);
      end
    end
  end

  for (genvar g = 0; g < fss_pkg::NREG; g++) begin : g_tmg
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        o_timing[g] <= fss_pkg::TMG_RST[g];
      end else if (i_ce) begin
        if (reg_wr && o_unlocked && reg_addr == fss_pkg::TMG_OFS[g]) begin
          o_timing[g] <= data_full;
        end
      end
    end
  end

  always_comb begin
    reg_rd_val = (reg_addr == fss_pkg::LOCK_ADDR) ? lock_q : 16'h0000;
    for (int i = 0; i < fss_pkg::NREG; i++) begin
      if (reg_addr == fss_pkg::TMG_OFS[i]) begin
        reg_rd_val = o_timing[i];
      end
    end
  end

  // ------------------------------------------------------------
  // power states
  // ------------------------------------------------------------
  logic [fss_pkg::IDLE_W-1:0] idle_q;
  logic busy_q, pend_q, chk_q;
  logic active;

  assign active = (o_pwr_state == fss_pkg::PWR_ACTIVE);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pwr_state <= fss_pkg::PWR_ACTIVE;
      idle_q <= '0;
    end else if (i_ce) begin
      if (!cs_s_q[1] || busy_q || pend_q || chk_q) begin
        idle_q <= '0;
      end else if (o_pwr_state != fss_pkg::PWR_WAKE && idle_q != '1) begin
        idle_q <= idle_q + 1'b1;
      end
      unique case (o_pwr_state)
        fss_pkg::PWR_ACTIVE: begin
          if (idle_q == fss_pkg::IDLE_W'(STANDBY_CYC)) begin
            o_pwr_state <= fss_pkg::PWR_STANDBY;
          end
        end
        fss_pkg::PWR_STANDBY: begin
          if (cs_fall) begin
            o_pwr_state <= fss_pkg::PWR_WAKE;
          end else if (idle_q == fss_pkg::IDLE_W'(SLEEP_CYC)) begin
            o_pwr_state <= fss_pkg::PWR_SLEEP;
          end
        end
        fss_pkg::PWR_SLEEP: begin
          if (cs_fall) begin
            o_pwr_state <= fss_pkg::PWR_WAKE;
            idle_q <= '0;
          end
        end
        fss_pkg::PWR_WAKE: begin
          idle_q <= idle_q + 1'b1;
          if (idle_q == fss_pkg::IDLE_W'(fss_pkg::WAKE_CYC)) begin
            o_pwr_state <= fss_pkg::PWR_ACTIVE;
            idle_q <= '0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // array access and operation queue
  // ------------------------------------------------------------
  fss_pkg::fss_op_s pend_op_q;
  logic rd_cap_q, rd_err_pend_q;
  logic [15:0] rd_word_q;
  logic [20:0] addr_q;
  logic inv_hit, fail_hit;

  assign inv_hit = rd_cap_q & chk_q & (|(o_op.data & ~i_rd_data));
  assign fail_hit = i_op_done & i_op_fail & busy_q;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_req <= 1'b0;
      o_op_req <= 1'b0;
      o_op <= '0;
      pend_op_q <= '0;
      pend_q <= 1'b0;
      chk_q <= 1'b0;
      busy_q <= 1'b0;
      rd_cap_q <= 1'b0;
      rd_err_pend_q <= 1'b0;
      rd_word_q <= 16'h0000;
      addr_q <= 21'h000000;
    end else if (i_ce) begin
      o_rd_req <= 1'b0;
      o_op_req <= 1'b0;
      rd_cap_q <= o_rd_req;
      if (cs_rise) begin
        rd_err_pend_q <= 1'b0;
      end
      if (rd_go) begin
        if (cmd == fss_pkg::CMD_STATUS) begin
          rd_word_q <= {4'h0, REV_ID, 2'b00, o_pwr_state == fss_pkg::PWR_WAKE | pend_q,
                        busy_q & (o_op.kind != fss_pkg::OP_PROG), 2'b00, active, 1'b0};
        end else if (cmd == fss_pkg::CMD_REG_RD) begin
          rd_word_q <= reg_rd_val;
        end else begin
          o_op.addr <= (cmd == fss_pkg::CMD_RD) ? word_addr : addr_q + 21'h000001;
          addr_q <= (cmd == fss_pkg::CMD_RD) ? word_addr : addr_q + 21'h000001;
          if (active) begin
            o_rd_req <= 1'b1;
          end else begin
            rd_word_q <= 16'h0000;
            rd_err_pend_q <= 1'b1;
          end
        end
      end else if (rd_cap_q) begin
        if (chk_q) begin
          chk_q <= 1'b0;
          if (!inv_hit) begin
            o_op_req <= 1'b1;
            busy_q <= 1'b1;
          end
        end else begin
          rd_word_q <= i_rd_data;
        end
      end else if (pend_q && active && cs_s_q[1] && !busy_q && !chk_q) begin
        pend_q <= 1'b0;
        o_op <= pend_op_q;
        if (pend_op_q.kind == fss_pkg::OP_PROG) begin
          o_rd_req <= 1'b1;
          chk_q <= 1'b1;
        end else begin
          o_op_req <= 1'b1;
          busy_q <= 1'b1;
        end
      end
      if (i_op_done) begin
        busy_q <= 1'b0;
      end
      if (exec) begin
        unique case (cmd)
          fss_pkg::CMD_WR: begin
            pend_q <= 1'b1;
            pend_op_q <= '{fss_pkg::OP_PROG, word_addr, data_full};
            addr_q <= word_addr;
          end
          fss_pkg::CMD_WR_AUTO: begin
            pend_q <= 1'b1;
            pend_op_q <= '{fss_pkg::OP_PROG, addr_q + 21'h000001, data_auto};
            addr_q <= addr_q + 21'h000001;
          end
          fss_pkg::CMD_ERASE: begin
            pend_q <= 1'b1;
            pend_op_q <= '{fss_pkg::OP_ERASE, word_addr, 16'h0000};
          end
          fss_pkg::CMD_VALID: begin
            pend_q <= 1'b1;
            pend_op_q <= '{fss_pkg::OP_VALID, word_addr, 16'h0000};
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // sticky error flags
  // ------------------------------------------------------------
  logic err_fail_q, err_inv_q, clr;

  assign clr = exec && cmd == fss_pkg::CMD_CTRL && data_auto == fss_pkg::CTRL_CLEAR;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      err_fail_q <= 1'b0;
      err_inv_q <= 1'b0;
    end else if (i_ce) begin
      err_fail_q <= (err_fail_q & ~clr) | fail_hit;
      err_inv_q <= (err_inv_q & ~clr) | inv_hit;
    end
  end

  // ------------------------------------------------------------
  // quick status latched at frame end
  // ------------------------------------------------------------
  logic [7:0] qs_q;
  logic wr_pending, er_pending;

  assign wr_pending = (pend_q & pend_op_q.kind == fss_pkg::OP_PROG) | chk_q |
                      (busy_q & o_op.kind == fss_pkg::OP_PROG);
  assign er_pending = (pend_q & pend_op_q.kind != fss_pkg::OP_PROG) |
                      (busy_q & o_op.kind != fss_pkg::OP_PROG);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      qs_q <= 8'h00;
    end else if (i_ce && cs_rise) begin
      qs_q <= 8'h00;
      qs_q[fss_pkg::QS_FAIL] <= err_fail_q;
      qs_q[fss_pkg::QS_INVALID] <= err_inv_q;
      qs_q[fss_pkg::QS_RD_ERR] <= rd_err_pend_q;
      qs_q[fss_pkg::QS_FRAME] <= (len != 3'h0) && !complete;
      qs_q[fss_pkg::QS_DEV_BUSY] <= exec & (cmd == fss_pkg::CMD_WR |
        cmd == fss_pkg::CMD_WR_AUTO | cmd == fss_pkg::CMD_ERASE |
        cmd == fss_pkg::CMD_VALID) | busy_q | pend_q | chk_q;
      qs_q[fss_pkg::QS_WR_BUSY] <= wr_pending;
      qs_q[fss_pkg::QS_ER_BUSY] <= er_pending;
    end
  end

  // ------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------
  logic [6:0] so_sh_q;
  logic [5:0] out_at;
  logic [7:0] next_byte;

  assign out_at = {len - 3'h2, 3'b000};

  always_comb begin
    next_byte = 8'h00;
    if (rd_at(cmd) != 6'h00 && bit_cnt_q == out_at) begin
      next_byte = rd_word_q[15:8];
    end else if (rd_at(cmd) != 6'h00 && bit_cnt_q == out_at + 6'h08) begin
      next_byte = rd_word_q[7:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
      so_sh_q <= 7'h00;
    end else if (i_ce) begin
      o_so_oe <= ~cs_s_q[1];
      if (cs_fall) begin
        o_so <= qs_q[7];
        so_sh_q <= qs_q[6:0];
      end else if (sck_fall && bit_cnt_q != 6'h00) begin
        if (bit_cnt_q[2:0] == 3'h0) begin
          o_so <= next_byte[7];
          so_sh_q <= next_byte[6:0];
        end else begin
          o_so <= so_sh_q[6];
          so_sh_q <= {so_sh_q[5:0], 1'b0};
        end
      end
    end
  end

endmodule : fss_flash_status

`default_nettype wire

// ---- verif/fss_flash_status_props.sv ----
// port assertions for the flash status block
`timescale 1ns/1ns
`default_nettype none
module fss_flash_status_chk #(
  parameter int STANDBY_CYC = 40,
  parameter int SLEEP_CYC = 80
) (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // serial pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic o_so,
  input wire logic o_so_oe,
  // flash array side
  input wire logic o_rd_req,
  input wire logic o_op_req,
  input wire fss_pkg::fss_op_s o_op,
  input wire logic [15:0] i_rd_data,
  input wire logic i_op_done,
  input wire logic i_op_fail,
  // timing and power
  input wire logic [fss_pkg::NREG-1:0][15:0] o_timing,
  input wire fss_pkg::fss_pwr_e o_pwr_state,
  input wire logic o_unlocked
);
  // ------------------------------------------------------------
  // idle time since chip select released
  // ------------------------------------------------------------
  logic [19:0] idle_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_q <= 20'h0;
    end else if (!i_cs_n) begin
      idle_q <= 20'h0;
    end else if (idle_q != 20'hfffff) begin
      idle_q <= idle_q + 20'h1;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  chk_oe_follow_cs: assert property ($fell(i_cs_n) |-> ##[1:4] o_so_oe)
    else $error("so enable not raised after select");
  chk_oe_idle_off: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("so enable high while deselected");
  chk_op_when_active: assert property (o_op_req |-> o_pwr_state == fss_pkg::PWR_ACTIVE)
    else $error("array operation started while not active");
  chk_wake_on_access: assert property ((o_pwr_state inside {fss_pkg::PWR_SLEEP,
    fss_pkg::PWR_STANDBY}) && $fell(i_cs_n) |-> ##[1:5] o_pwr_state == fss_pkg::PWR_WAKE)
    else $error("access did not start wake");
  chk_wake_ends: assert property ($rose(o_pwr_state == fss_pkg::PWR_WAKE)
    |-> ##[240:260] o_pwr_state == fss_pkg::PWR_ACTIVE)
    else $error("wake did not end in active");
  chk_standby_idle: assert property ($rose(o_pwr_state == fss_pkg::PWR_STANDBY)
    |-> i_cs_n && idle_q >= STANDBY_CYC - 4)
    else $error("standby entered too early");
  chk_sleep_idle: assert property ($rose(o_pwr_state == fss_pkg::PWR_SLEEP)
    |-> $past(o_pwr_state) == fss_pkg::PWR_STANDBY && idle_q >= SLEEP_CYC - 4)
    else $error("sleep entered too early or not from standby");
  chk_lock_timing: assert property (!$past(o_unlocked) |-> $stable(o_timing))
    else $error("timing changed while locked");
endmodule : fss_flash_status_chk

bind fss_flash_status fss_flash_status_chk #(.STANDBY_CYC(STANDBY_CYC),
  .SLEEP_CYC(SLEEP_CYC)) chk_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe),
  .o_rd_req(o_rd_req), .o_op_req(o_op_req), .o_op(o_op), .i_rd_data(i_rd_data),
  .i_op_done(i_op_done), .i_op_fail(i_op_fail), .o_timing(o_timing),
  .o_pwr_state(o_pwr_state), .o_unlocked(o_unlocked));
`default_nettype wire

// ---- verif/fss_spi_host.sv ----
// behavioural serial host shifting one command frame per request
`timescale 1ns/1ns
`default_nettype none
module fss_spi_host (
  // clock and request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [2:0] i_len,
  input wire logic [55:0] i_tx,
  // serial pins
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  // result
  output logic [55:0] o_rx,
  output logic o_done
);
  int i;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_rx = '0;
    o_done = 1'b1;
  end
  always @(posedge i_clk) begin
    if (i_go) begin
      o_done = 1'b0;
      o_rx = '0;
      #3;
      o_cs_n = 1'b0;
      for (i = 0; i < 8 * i_len; i++) begin
        o_si = i_tx[55 - i];
        #40;
        o_sck = 1'b1;
        o_rx[55 - i] = i_so;
        #40;
        o_sck = 1'b0;
      end
      #40;
      o_cs_n = 1'b1;
      o_si = ~o_si;
      #120;
      o_done = 1'b1;
    end
  end
endmodule : fss_spi_host
`default_nettype wire

// ---- verif/fss_flash_status_tb_top.sv ----
// self-checking bench for the flash status block
`timescale 1ns/1ns
`default_nettype none
module fss_flash_status_tb_top;
  typedef struct packed {
    logic [2:0] len;
    logic [55:0] tx;
    logic [7:0] qs;
    logic [16:0] wd;
    logic fail;
  } fss_row_s;
  localparam logic [55:0] QST = 56'hff000000000000;
  localparam fss_row_s ROWS [23] = '{
    '{3'h3, 56'h22000000000000, 8'h00, 17'h10502, 1'b0},
    '{3'h7, 56'h1700000000ff00, 8'h00, 17'h0, 1'b0},
    '{3'h1, QST, 8'h08, 17'h0, 1'b0},
    '{3'h1, QST, 8'h00, 17'h0, 1'b0},
    '{3'h7, 56'h17000000ffff00, 8'h00, 17'h0, 1'b0},
    '{3'h1, QST, 8'h08, 17'h0, 1'b0},
    '{3'h1, QST, 8'h04, 17'h0, 1'b0},
    '{3'h1, QST, 8'h04, 17'h0, 1'b0},
    '{3'h4, 56'h1f004000000000, 8'h04, 17'h0, 1'b0},
    '{3'h1, QST, 8'h04, 17'h0, 1'b0},
    '{3'h1, QST, 8'h00, 17'h0, 1'b0},
    '{3'h7, 56'h1700000100ff00, 8'h00, 17'h0, 1'b1},
    '{3'h1, QST, 8'h08, 17'h0, 1'b1},
    '{3'h1, QST, 8'h01, 17'h0, 1'b0},
    '{3'h4, 56'h1f004000000000, 8'h01, 17'h0, 1'b0},
    '{3'h1, QST, 8'h01, 17'h0, 1'b0},
    '{3'h1, QST, 8'h00, 17'h0, 1'b0},
    '{3'h3, 56'h17000000000000, 8'h00, 17'h0, 1'b0},
    '{3'h1, QST, 8'h40, 17'h0, 1'b0},
    '{3'h1, QST, 8'h00, 17'h0, 1'b0},
    '{3'h7, 56'h15000000000000, 8'h00, 17'h100ff, 1'b0},
    '{3'h7, 56'h1d00f0042bc000, 8'h00, 17'h0, 1'b0},
    '{3'h7, 56'h1e00f004000000, 8'h00, 17'h12bc0, 1'b0}};
  localparam logic [15:0] BAND [11] = '{16'h0324, 16'h3028, 16'h0404, 16'h0404,
    16'h00a0, 16'h0404, 16'h0010, 16'h2a30, 16'h07d0, 16'h0404, 16'h0020};
  logic core_clk, rst, cs_n, sck, si, so, rd_req, op_req, unlk, f_go, f_done;
  logic rdv_q, done_q, fail_q, fail_en;
  logic [2:0] f_len;
  logic [4:0] cnt_q;
  logic [15:0] arr_q, pend_q, rd_data, wd;
  logic [55:0] f_tx, f_rx;
  logic [fss_pkg::NREG-1:0][15:0] timing;
  fss_pkg::fss_op_s op;
  fss_pkg::fss_pwr_e pwr;
  int n_fail = 0;
  int checked = 0;
  fss_flash_status #(.STANDBY_CYC(400), .SLEEP_CYC(800), .REV_ID(4'h5)) dut_u (
    .i_core_clk(core_clk), .i_rst(rst), .i_ce(1'b1), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .o_so(so), .o_so_oe(), .o_rd_req(rd_req), .o_op_req(op_req), .o_op(op),
    .i_rd_data(rd_data), .i_op_done(done_q), .i_op_fail(fail_q), .o_timing(timing),
    .o_pwr_state(pwr), .o_unlocked(unlk));
  fss_spi_host host_u (.i_clk(core_clk), .i_go(f_go), .i_len(f_len), .i_tx(f_tx),
    .i_so(so), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_rx(f_rx), .o_done(f_done));
  // ------------------------------------------------------------
  // flash array model
  // ------------------------------------------------------------
  assign rd_data = rdv_q ? arr_q : ~arr_q;
  initial begin
    arr_q = 16'h00ff;
    cnt_q = 5'h0;
    fail_q = 1'b0;
  end
  always @(posedge core_clk) begin
    rdv_q <= rd_req;
    done_q <= 1'b0;
    if (op_req) begin
      cnt_q <= 5'h14;
      pend_q <= op.data;
    end else if (cnt_q != 5'h0) begin
      cnt_q <= cnt_q - 5'h1;
      if (cnt_q == 5'h1) begin
        done_q <= 1'b1;
        fail_q <= fail_en;
        if (!fail_en) arr_q <= pend_q;
      end
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic cmp_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp_byte
  task automatic cmp_word(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp_word
  task automatic frame(input logic [2:0] len, input logic [55:0] tx);
    int n;
    @(posedge core_clk);
    #1;
    f_len = len;
    f_tx = tx;
    f_go = 1'b1;
    @(posedge core_clk);
    #1;
    f_go = 1'b0;
    n = 0;
    while (f_done !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    cmp_byte("frame done", 8'h01, {7'h0, f_done});
    wd = 16'(f_rx >> (56 - 8 * len));
  endtask : frame
  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    #400000;
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    close_out();
  end
  initial begin
    rst = 1'b1;
    f_go = 1'b0;
    f_len = 3'h0;
    f_tx = '0;
    fail_en = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int r = 0; r < 23; r++) begin
      fail_en = ROWS[r].fail;
      frame(ROWS[r].len, ROWS[r].tx);
      cmp_byte("quick status", ROWS[r].qs, f_rx[55:48]);
      if (ROWS[r].wd[16]) cmp_word("read word", ROWS[r].wd[15:0], wd);
    end
    $display("test rows done");
    for (int k = 0; k < fss_pkg::NREG; k++) begin
      frame(3'h7, {8'h1d, 8'h00, fss_pkg::TMG_OFS[k], BAND[k], 8'h00});
      frame(3'h7, {8'h1e, 8'h00, fss_pkg::TMG_OFS[k], 24'h0});
      cmp_word("timing readback", BAND[k], wd);
      cmp_word("timing port", BAND[k], timing[k]);
    end
    frame(3'h7, {8'h1d, 8'h00, fss_pkg::LOCK_ADDR, fss_pkg::LOCK_KEY, 8'h00});
    cmp_byte("unlocked", 8'h00, {7'h0, unlk});
    frame(3'h7, {8'h1d, 24'h008006, 16'h1234, 8'h00});
    frame(3'h1, QST);
    cmp_byte("quick status", 8'h00, f_rx[55:48]);
    cmp_word("locked timing", BAND[0], timing[0]);
    $display("test timing done");
    #1 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int k = 0; k < fss_pkg::NREG; k++) begin
      cmp_word("timing default", fss_pkg::TMG_RST[k], timing[k]);
    end
    cmp_byte("unlocked", 8'h00, {7'h0, unlk});
    $display("test reset done");
    repeat (1300) @(posedge core_clk);
    cmp_byte("power state", {6'h0, fss_pkg::PWR_SLEEP}, {6'h0, pwr});
    frame(3'h4, 56'h16000000000000);
    cmp_word("asleep read", 16'h0000, wd);
    frame(3'h1, QST);
    cmp_byte("quick status", 8'h02, f_rx[55:48]);
    repeat (300) @(posedge core_clk);
    cmp_byte("power state", {6'h0, fss_pkg::PWR_ACTIVE}, {6'h0, pwr});
    repeat (150) @(posedge core_clk);
    cmp_byte("power state", {6'h0, fss_pkg::PWR_STANDBY}, {6'h0, pwr});
    frame(3'h3, 56'h22000000000000);
    cmp_word("status waking", 16'h0520, wd);
    $display("test sleep done");
    close_out();
  end
endmodule : fss_flash_status_tb_top
`default_nettype wire
